// File: hdl/gdc_regs.svh
/*
 * Named constants for the gate driver configuration block: field widths,
 * reset values, special field codes and timing figures.
 * Assumes a 10 MHz core clock; included by the package and the modules.
 */
`ifndef GDC_REGS_SVH
`define GDC_REGS_SVH

// ************************************************************
// Field widths
// ************************************************************
`define GDC_TIME_W         8
`define GDC_LEVEL_W        4
`define GDC_VTO_W          16

// ************************************************************
// Reset values and special codes
// ************************************************************
`define GDC_TIME_ZERO      8'h00
`define GDC_TIME_ALL_ONES  8'hff
`define GDC_LEVEL_RST      4'h0
`define GDC_FLAG_RST       1'h0
`define GDC_CLAMP_IDLE     1'h1

// ************************************************************
// Timing
// ************************************************************
`define GDC_CLK_PERIOD_NS  100
`define GDC_XFER_PERIOD_NS 10000
`define GDC_XFER_CYC       (`GDC_XFER_PERIOD_NS / `GDC_CLK_PERIOD_NS)
`define GDC_XFER_W         8
`define GDC_VTO_SHORT_US   100
`define GDC_VTO_LONG_US    1000
`define GDC_OSC_DIV        2

`endif

// File: hdl/gdc_pkg.sv
/*
 * Types shared by the gate driver configuration block.
 * Assumes gdc_regs.svh is on the include path.
 */
`include "gdc_regs.svh"

package gdc_pkg;

	// ************************************************************
	// Operating modes seen by this block
	// ************************************************************
	typedef enum logic [1:0] {
		GDC_OPM_OTHER,
		GDC_OPM_CONFIG,
		GDC_OPM_NORMAL,
		GDC_OPM_CALIB
	} gdc_opmode_t;

	// ************************************************************
	// Static configuration image, loaded as one word
	// ************************************************************
	typedef struct packed {
		logic                    vbe_comp_enable;
		logic                    outstage_monitor_disable;
		logic                    shutdown_pin_classa_suppress;
		logic                    desaturation_sense_clamp_enable;
		logic                    pulse_suppressor_enable;
		logic                    verify_timeout_select;
		logic                    calibration_enable_field;
		logic [`GDC_TIME_W-1:0]  regular_turnoff_delay_value;
		logic [`GDC_TIME_W-1:0]  safe_turnoff_delay;
		logic [`GDC_LEVEL_W-1:0] safe_plateau_level;
		logic [`GDC_TIME_W-1:0]  desaturation_sense_blanking_time;
		logic [`GDC_TIME_W-1:0]  overcurrent_blanking_time;
		logic [`GDC_TIME_W-1:0]  clamp_activation_time;
	} gdc_static_cfg_t;

	// ************************************************************
	// Output stage sequence state
	// ************************************************************
	typedef enum logic [1:0] {
		GDC_ST_OFF,
		GDC_ST_ON,
		GDC_ST_PLATEAU
	} gdc_stage_t;

endpackage

// File: hdl/gdc_tick_div.sv
/*
 * Divider that models the output stage oscillator as a one-cycle enable.
 * Assumes a single clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`include "gdc_regs.svh"

module gdc_tick_div #(
	parameter int DIV = `GDC_OSC_DIV
) (
	input  wire logic core_clk,
	input  wire logic rst,
	output logic      tick_ff
);

	logic [7:0] cnt_ff;

	// Free-running count; the tick fires once every DIV cycles.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cnt_ff  <= 8'h00;
			tick_ff <= 1'b0;
		end else if (cnt_ff == 8'(DIV - 1)) begin
			cnt_ff  <= 8'h00;
			tick_ff <= 1'b1;
		end else begin
			cnt_ff  <= cnt_ff + 8'h01;
			tick_ff <= 1'b0;
		end
	end

endmodule

// File: hdl/gdc_down_timer.sv
/*
 * Loadable down counter stepped by the oscillator enable.
 * A load of zero leaves the timer idle, so a zero time means no window.
 */
`timescale 1ns/1ps
`include "gdc_regs.svh"

module gdc_down_timer #(
	parameter int W = `GDC_TIME_W
) (
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic         tick,
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	output logic              busy
);

	logic [W-1:0] cnt_ff;

	// Load wins over counting so a restart is never missed.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cnt_ff <= '0;
		end else if (load) begin
			cnt_ff <= load_val;
		end else if (tick && cnt_ff != '0) begin
			cnt_ff <= cnt_ff - W'(1);
		end
	end

	assign busy = (cnt_ff != '0);

endmodule

// File: hdl/gdc_core.sv
/*
 * Gate driver configuration and control: static option bits frozen after
 * configuration, two-level turn-off sequencing, blanking windows, clamp
 * timing, runtime plateau transfer and timing calibration.
 * Assumes all inputs are synchronous to core_clk and strobes are one cycle.
 */
// Function
// - VBE compensation follows its config bit
// - Monitor disable bit stops output stage monitoring
// - Pin tristate suppresses class A, still flags
// - Desaturation_sense clamp: off plus blanking, else blanking
// - Pulse suppressor enable; regular delay meets minimum
// - Time-out select bit picks verification duration
// - Separate regular and safe turn-off delays
// - Zero delay means hard turn-off
// - Safe plateau from static field, below regular
// - Desaturation_sense blanking from field, software minimum
// - Overcurrent blanking from field, zero disables
// - Clamp time; zero high, all ones low
// - Runtime plateau written, transferred periodically
// - Primary echo shows last acknowledged plateau
// - Secondary status shows plateau in use
// - Safe plateau static only
// - Weak turn-on level written at runtime
// - Plateau latched at sequence start
// - Calibration counts PWM width into regular delay
// - Static writes only in config mode, then frozen
`timescale 1ns/1ps
`include "gdc_regs.svh"

module gdc_core #(
	parameter int              OSC_DIV     = `GDC_OSC_DIV,
	parameter logic [`GDC_VTO_W-1:0] VTO_SHORT_CYC =
		`GDC_VTO_W'(`GDC_VTO_SHORT_US * 1000 / `GDC_CLK_PERIOD_NS),
	parameter logic [`GDC_VTO_W-1:0] VTO_LONG_CYC  =
		`GDC_VTO_W'(`GDC_VTO_LONG_US * 1000 / `GDC_CLK_PERIOD_NS)
) (
	input  wire logic                       core_clk,
	input  wire logic                       rst,
	input  wire gdc_pkg::gdc_opmode_t       opmode,
	input  wire logic                       leave_config_command,
	input  wire logic                       static_wr,
	input  wire gdc_pkg::gdc_static_cfg_t   static_wdata,
	input  wire logic                       plateau_wr,
	input  wire logic [`GDC_LEVEL_W-1:0]    plateau_wdata,
	input  wire logic                       weak_turnon_wr,
	input  wire logic [`GDC_LEVEL_W-1:0]    weak_turnon_wdata,
	input  wire logic                       pwm_in,
	input  wire logic                       safe_turnoff_req,
	input  wire logic                       external_shutdown_pin,
	input  wire logic                       tristate_error_clear,
	output gdc_pkg::gdc_static_cfg_t        static_cfg_ff,
	output logic                            frozen_ff,
	output logic                            vbe_comp_enable_ff,
	output logic                            outstage_monitoring_ff,
	output logic                            tristate_ff,
	output logic                            tristate_error_flag_ff,
	output logic                            classa_event_ff,
	output logic                            desaturation_sense_clamp_ff,
	output logic                            desaturation_sense_blank_ff,
	output logic                            ocp_blank_ff,
	output logic [`GDC_VTO_W-1:0]           verify_timeout_ff,
	output logic                            turn_on_output_ff,
	output logic                            turn_off_output_ff,
	output logic                            plateau_active_ff,
	output logic [`GDC_LEVEL_W-1:0]         applied_plateau_ff,
	output logic [`GDC_LEVEL_W-1:0]         applied_turnon_level_ff,
	output logic                            active_clamp_output_ff,
	output logic [`GDC_LEVEL_W-1:0]         regular_plateau_level_ctrl_ff,
	output logic [`GDC_LEVEL_W-1:0]         primary_plateau_echo_ff,
	output logic [`GDC_LEVEL_W-1:0]         secondary_plateau_in_use_ff,
	output logic [`GDC_LEVEL_W-1:0]         weak_turnon_level_ctrl_ff,
	output logic                            cal_busy_ff
);

	// ************************************************************
	// Internal signals
	// ************************************************************
	gdc_pkg::gdc_stage_t         stage_ff;
	logic                        pwm_q_ff;
	logic                        pwm_rise;
	logic                        pwm_fall;
	logic                        tick;
	logic                        cfg_write_ok;
	logic                        switch_ok;
	logic                        start_on;
	logic                        start_off;
	logic [`GDC_TIME_W-1:0]      off_delay;
	logic                        hard_off;
	logic                        plateau_busy;
	logic                        plateau_done;
	logic                        desaturation_sense_busy;
	logic                        ocp_busy;
	logic                        clamp_busy;
	logic [`GDC_TIME_W-1:0]      cal_cnt_ff;
	logic [`GDC_XFER_W-1:0]      xfer_cnt_ff;
	logic                        xfer_now;

	// Delay to use for the turn-off now starting: safe or regular.
	function automatic logic [`GDC_TIME_W-1:0] pick_delay(
		input logic                   safe,
		input gdc_pkg::gdc_static_cfg_t cfg
	);
		pick_delay = safe ? cfg.safe_turnoff_delay : cfg.regular_turnoff_delay_value;
	endfunction

	// ************************************************************
	// Shared decode
	// ************************************************************
	assign pwm_rise     = pwm_in & ~pwm_q_ff;
	assign pwm_fall     = ~pwm_in & pwm_q_ff;
	assign cfg_write_ok = static_wr && opmode == gdc_pkg::GDC_OPM_CONFIG && !frozen_ff;
	assign switch_ok    = (opmode == gdc_pkg::GDC_OPM_NORMAL) && !tristate_ff;
	// With the suppressor on, an on request during a plateau is dropped.
	assign start_on     = switch_ok && pwm_rise && stage_ff == gdc_pkg::GDC_ST_OFF;
	assign start_off    = stage_ff == gdc_pkg::GDC_ST_ON && (pwm_fall || safe_turnoff_req);
	assign off_delay    = pick_delay(safe_turnoff_req, static_cfg_ff);
	assign hard_off     = start_off && off_delay == `GDC_TIME_ZERO;
	assign plateau_done = stage_ff == gdc_pkg::GDC_ST_PLATEAU && !plateau_busy;
	assign xfer_now     = xfer_cnt_ff == `GDC_XFER_W'(`GDC_XFER_CYC - 1);

	// ************************************************************
	// Oscillator enable and timers
	// ************************************************************
	gdc_tick_div #(.DIV(OSC_DIV)) u_osc (
		.core_clk (core_clk),
		.rst      (rst),
		.tick_ff  (tick)
	);

	gdc_down_timer u_plateau (
		.core_clk (core_clk),
		.rst      (rst),
		.tick     (tick),
		.load     (start_off),
		.load_val (off_delay),
		.busy     (plateau_busy)
	);

	gdc_down_timer u_desaturation_sense (
		.core_clk (core_clk),
		.rst      (rst),
		.tick     (tick),
		.load     (start_on),
		.load_val (static_cfg_ff.desaturation_sense_blanking_time),
		.busy     (desaturation_sense_busy)
	);

	gdc_down_timer u_ocp (
		.core_clk (core_clk),
		.rst      (rst),
		.tick     (tick),
		.load     (start_on),
		.load_val (static_cfg_ff.overcurrent_blanking_time),
		.busy     (ocp_busy)
	);

	gdc_down_timer u_clamp (
		.core_clk (core_clk),
		.rst      (rst),
		.tick     (tick),
		.load     (hard_off || plateau_done),
		.load_val (static_cfg_ff.clamp_activation_time),
		.busy     (clamp_busy)
	);

	// ************************************************************
	// Static configuration and freeze
	// ************************************************************

	// Static image; calibration may still rewrite the regular delay later.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			static_cfg_ff <= '0;
		end else if (cfg_write_ok) begin
			static_cfg_ff <= static_wdata;
		end else if (cal_busy_ff && pwm_fall) begin
			static_cfg_ff.regular_turnoff_delay_value <= cal_cnt_ff;
		end
	end

	// Freeze on leaving configuration; only a reset thaws it.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			frozen_ff <= `GDC_FLAG_RST;
		end else if (leave_config_command && opmode == gdc_pkg::GDC_OPM_CONFIG) begin
			frozen_ff <= 1'b1;
		end
	end

	// Option bits fanned out to the analog side.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			vbe_comp_enable_ff     <= `GDC_FLAG_RST;
			outstage_monitoring_ff <= `GDC_FLAG_RST;
			verify_timeout_ff      <= VTO_SHORT_CYC;
		end else begin
			vbe_comp_enable_ff     <= static_cfg_ff.vbe_comp_enable;
			outstage_monitoring_ff <= !static_cfg_ff.outstage_monitor_disable &&
				stage_ff != gdc_pkg::GDC_ST_OFF;
			verify_timeout_ff      <= static_cfg_ff.verify_timeout_select ?
				VTO_LONG_CYC : VTO_SHORT_CYC;
		end
	end

	// ************************************************************
	// Shutdown pin handling
	// ************************************************************

	// Tristate holds until PWM is low; the error flag's set beats its clear.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			tristate_ff            <= `GDC_FLAG_RST;
			tristate_error_flag_ff <= `GDC_FLAG_RST;
			classa_event_ff        <= `GDC_FLAG_RST;
		end else begin
			if (external_shutdown_pin) begin
				tristate_ff <= 1'b1;
			end else if (!pwm_in) begin
				tristate_ff <= 1'b0;
			end
			if (external_shutdown_pin) begin
				tristate_error_flag_ff <= 1'b1;
			end else if (tristate_error_clear) begin
				tristate_error_flag_ff <= 1'b0;
			end
			classa_event_ff <= external_shutdown_pin &&
				!static_cfg_ff.shutdown_pin_classa_suppress;
		end
	end

	// ************************************************************
	// Switching sequence
	// ************************************************************

	// Edge reference for PWM.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pwm_q_ff <= 1'b0;
		end else begin
			pwm_q_ff <= pwm_in;
		end
	end

	// Stage sequencing; a shutdown event overrides every state.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			stage_ff           <= gdc_pkg::GDC_ST_OFF;
			turn_on_output_ff  <= 1'b0;
			turn_off_output_ff <= 1'b0;
			plateau_active_ff  <= 1'b0;
		end else if (external_shutdown_pin) begin
			stage_ff           <= gdc_pkg::GDC_ST_OFF;
			turn_on_output_ff  <= 1'b0;
			turn_off_output_ff <= 1'b0;
			plateau_active_ff  <= 1'b0;
		end else begin
			case (stage_ff)
				gdc_pkg::GDC_ST_OFF: begin
					if (start_on) begin
						stage_ff           <= gdc_pkg::GDC_ST_ON;
						turn_on_output_ff  <= 1'b1;
						turn_off_output_ff <= 1'b0;
					end
				end
				gdc_pkg::GDC_ST_ON: begin
					if (hard_off) begin
						stage_ff           <= gdc_pkg::GDC_ST_OFF;
						turn_on_output_ff  <= 1'b0;
						turn_off_output_ff <= 1'b1;
					end else if (start_off) begin
						stage_ff           <= gdc_pkg::GDC_ST_PLATEAU;
						turn_on_output_ff  <= 1'b0;
						plateau_active_ff  <= 1'b1;
					end
				end
				gdc_pkg::GDC_ST_PLATEAU: begin
					// The suppressor keeps PWM edges out until the plateau ends.
					if (plateau_done || !static_cfg_ff.pulse_suppressor_enable &&
						pwm_rise) begin
						stage_ff           <= gdc_pkg::GDC_ST_OFF;
						turn_off_output_ff <= 1'b1;
						plateau_active_ff  <= 1'b0;
					end
				end
				default: begin
					stage_ff <= gdc_pkg::GDC_ST_OFF;
				end
			endcase
		end
	end

	// Levels are captured at sequence start and held until the next one.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			applied_plateau_ff      <= `GDC_LEVEL_RST;
			applied_turnon_level_ff <= `GDC_LEVEL_RST;
		end else begin
			if (start_off) begin
				applied_plateau_ff <= safe_turnoff_req ?
					static_cfg_ff.safe_plateau_level :
					secondary_plateau_in_use_ff;
			end
			if (start_on) begin
				applied_turnon_level_ff <= weak_turnon_level_ctrl_ff;
			end
		end
	end

	// ************************************************************
	// Blanking and clamping
	// ************************************************************

	// The clamp pulls the sense pin low during blanking, and while off if enabled.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			desaturation_sense_clamp_ff <= 1'b0;
			desaturation_sense_blank_ff <= 1'b0;
			ocp_blank_ff   <= 1'b0;
		end else begin
			desaturation_sense_clamp_ff <= desaturation_sense_busy || (stage_ff == gdc_pkg::GDC_ST_OFF &&
				static_cfg_ff.desaturation_sense_clamp_enable);
			desaturation_sense_blank_ff <= desaturation_sense_busy;
			ocp_blank_ff   <= ocp_busy;
		end
	end

	// Clamp output is active low; the two end codes pin it to a fixed level.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			active_clamp_output_ff <= `GDC_CLAMP_IDLE;
		end else if (static_cfg_ff.clamp_activation_time == `GDC_TIME_ZERO) begin
			active_clamp_output_ff <= 1'b1;
		end else if (static_cfg_ff.clamp_activation_time == `GDC_TIME_ALL_ONES) begin
			active_clamp_output_ff <= 1'b0;
		end else begin
			active_clamp_output_ff <= !clamp_busy;
		end
	end

	// ************************************************************
	// Runtime plateau and weak turn-on levels
	// ************************************************************

	// Runtime fields ignore the freeze on purpose.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			regular_plateau_level_ctrl_ff <= `GDC_LEVEL_RST;
			weak_turnon_level_ctrl_ff     <= `GDC_LEVEL_RST;
		end else begin
			if (plateau_wr) begin
				regular_plateau_level_ctrl_ff <= plateau_wdata;
			end
			if (weak_turnon_wr) begin
				weak_turnon_level_ctrl_ff <= weak_turnon_wdata;
			end
		end
	end

	// Periodic transfer; the echo lags by one period like a real acknowledge.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			xfer_cnt_ff                 <= '0;
			secondary_plateau_in_use_ff <= `GDC_LEVEL_RST;
			primary_plateau_echo_ff     <= `GDC_LEVEL_RST;
		end else if (xfer_now) begin
			xfer_cnt_ff                 <= '0;
			secondary_plateau_in_use_ff <= regular_plateau_level_ctrl_ff;
			primary_plateau_echo_ff     <= secondary_plateau_in_use_ff;
		end else begin
			xfer_cnt_ff <= xfer_cnt_ff + `GDC_XFER_W'(1);
		end
	end

	// ************************************************************
	// Timing calibration
	// ************************************************************

	// PWM high time counted in oscillator ticks, saturating at full scale.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cal_busy_ff <= 1'b0;
			cal_cnt_ff  <= `GDC_TIME_ZERO;
		end else if (pwm_rise && opmode == gdc_pkg::GDC_OPM_CALIB &&
			static_cfg_ff.calibration_enable_field) begin
			cal_busy_ff <= 1'b1;
			cal_cnt_ff  <= `GDC_TIME_ZERO;
		end else if (cal_busy_ff && pwm_fall) begin
			cal_busy_ff <= 1'b0;
		end else if (cal_busy_ff && tick && cal_cnt_ff != `GDC_TIME_ALL_ONES) begin
			cal_cnt_ff <= cal_cnt_ff + `GDC_TIME_W'(1);
		end
	end

endmodule

// File: bench/gdc_core_asserts.sv
/* Port checker for gdc_core, bound into every instance of it.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`include "gdc_regs.svh"
module gdc_core_asserts #(
	parameter logic [`GDC_VTO_W-1:0]	VTO_SHORT_CYC = 16'h03e8,
	parameter logic [`GDC_VTO_W-1:0]	VTO_LONG_CYC = 16'h2710
) (
	input wire logic			core_clk,
	input wire logic			rst,
	input wire gdc_pkg::gdc_opmode_t	opmode,
	input wire logic			static_wr,
	input wire gdc_pkg::gdc_static_cfg_t	static_wdata,
	input wire logic			pwm_in,
	input wire logic			safe_turnoff_req,
	input wire logic			external_shutdown_pin,
	input wire gdc_pkg::gdc_static_cfg_t	static_cfg_ff,
	input wire logic			frozen_ff,
	input wire logic			vbe_comp_enable_ff,
	input wire logic			tristate_ff,
	input wire logic			tristate_error_flag_ff,
	input wire logic			classa_event_ff,
	input wire logic [`GDC_VTO_W-1:0]	verify_timeout_ff,
	input wire logic			turn_on_output_ff,
	input wire logic			turn_off_output_ff,
	input wire logic			plateau_active_ff,
	input wire logic			active_clamp_output_ff,
	input wire logic [`GDC_LEVEL_W-1:0]	regular_plateau_level_ctrl_ff,
	input wire logic [`GDC_LEVEL_W-1:0]	secondary_plateau_in_use_ff
);
	logic	wr_ok;
	logic	off_ok;

	// ********
	// Conditions
	// ********
	// A taken static write, and a regular turn-off request seen in the ON stage.
	assign wr_ok = static_wr && opmode == gdc_pkg::GDC_OPM_CONFIG && !frozen_ff;
	assign off_ok = opmode == gdc_pkg::GDC_OPM_NORMAL && !tristate_ff && turn_on_output_ff
		&& !safe_turnoff_req && !external_shutdown_pin;

	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);

	// ********
	// Assertions
	// ********
	// Values from before a reset are masked by the past-reset guards.
	rst_dflt_a: assert property ($past(rst) |-> static_cfg_ff == '0 && !frozen_ff &&
		active_clamp_output_ff && verify_timeout_ff == VTO_SHORT_CYC) else $error("bad reset value");
	wr_accept_a: assert property (wr_ok |=> static_cfg_ff == $past(static_wdata))
		else $error("static write not taken");
	vbe_follow_a: assert property (wr_ok |=> ##1
		vbe_comp_enable_ff == $past(static_wdata.vbe_comp_enable, 2)) else $error("bad vbe");
	vto_select_a: assert property (!$past(rst) |-> verify_timeout_ff ==
		($past(static_cfg_ff.verify_timeout_select) ? VTO_LONG_CYC : VTO_SHORT_CYC))
		else $error("bad time-out");
	sd_quiet_a: assert property (external_shutdown_pin &&
		static_cfg_ff.shutdown_pin_classa_suppress |=> !classa_event_ff && tristate_ff &&
		tristate_error_flag_ff) else $error("bad suppressed shutdown");
	hard_off_a: assert property (off_ok && $fell(pwm_in) &&
		static_cfg_ff.regular_turnoff_delay_value == `GDC_TIME_ZERO |=> turn_off_output_ff &&
		!plateau_active_ff) else $error("bad hard turn-off");
	two_level_a: assert property (off_ok && $fell(pwm_in) &&
		static_cfg_ff.regular_turnoff_delay_value != `GDC_TIME_ZERO |=> plateau_active_ff &&
		!turn_off_output_ff) else $error("bad plateau start");
	xfer_src_a: assert property (!$past(rst) && $changed(secondary_plateau_in_use_ff) |->
		secondary_plateau_in_use_ff == $past(regular_plateau_level_ctrl_ff))
		else $error("bad plateau transfer");

	cover property (wr_ok);
	cover property (plateau_active_ff);
	cover property (frozen_ff && classa_event_ff);
endmodule

bind gdc_core gdc_core_asserts #(.VTO_SHORT_CYC(VTO_SHORT_CYC), .VTO_LONG_CYC(VTO_LONG_CYC))
	gdc_core_asserts_i (.*);

// File: bench/gdc_host_pwm.sv
/* Host model: a PWM source that holds pwm_in high for a set number of cycles.
   Assumes the bench raises go for one cycle, away from the rising edge. */
`timescale 1ns/1ps
module gdc_host_pwm (
	input wire logic	core_clk,
	input wire logic	go,
	input wire logic [7:0]	len,
	output logic		pwm_in
);
	logic [7:0]	left_ff;

	initial begin
		left_ff = 8'h00;
		pwm_in = 1'b0;
	end
	// ********
	// Pulse timing
	// ********
	// The length is loaded whole, so a late request restarts the count and can cut a pulse short.
	always @(posedge core_clk) begin
		if (go)
			left_ff <= len;
		else if (left_ff != 8'h00)
			left_ff <= left_ff - 8'h01;
	end
	// Drive on the falling edge, well clear of the edge the block samples on.
	always @(negedge core_clk) begin
		pwm_in <= (left_ff != 8'h00);
	end
endmodule

// File: bench/gdc_core_tb_top.sv
/* Bench for gdc_core: resets, configures and switches the block, then checks ports.
   Assumes the host PWM model and the bound port checker. */
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
	$display("unexpected at %0t: got %h, expected %h", $time, (a), (b)); end end
module gdc_core_tb_top;
	localparam logic [15:0] VTO_L = 16'h0014;
	logic core_clk = 1'b0, rst = 1'b1, leave_config_command = 1'b0, static_wr = 1'b0;
	logic plateau_wr = 1'b0, weak_turnon_wr = 1'b0, safe_turnoff_req = 1'b0, go = 1'b0;
	logic external_shutdown_pin = 1'b0, pwm_in, seen_plat = 1'b0, seen_cla = 1'b0;
	logic [3:0] plateau_wdata = 4'h0, weak_turnon_wdata = 4'h0;
	logic [7:0] len = 8'h00;
	gdc_pkg::gdc_opmode_t opmode = gdc_pkg::GDC_OPM_OTHER;
	gdc_pkg::gdc_static_cfg_t static_wdata = '0, static_cfg_ff, c;
	logic frozen_ff, vbe_comp_enable_ff, outstage_monitoring_ff, tristate_ff, ocp_blank_ff;
	logic tristate_error_flag_ff, classa_event_ff, desaturation_sense_clamp_ff, desaturation_sense_blank_ff, cal_busy_ff;
	logic turn_on_output_ff, turn_off_output_ff, plateau_active_ff, active_clamp_output_ff;
	logic [3:0] applied_plateau_ff, applied_turnon_level_ff, regular_plateau_level_ctrl_ff;
	logic [3:0] primary_plateau_echo_ff, secondary_plateau_in_use_ff, weak_turnon_level_ctrl_ff;
	logic [15:0] verify_timeout_ff;
	int bad_count = 0, samples_checked = 0, n;

	gdc_core #(.VTO_LONG_CYC(VTO_L)) gdc_core_i (.*, .tristate_error_clear(1'b0));
	gdc_host_pwm gdc_host_pwm_i (.core_clk, .go, .len, .pwm_in);

	// ********
	// Clock, witnesses and tasks
	// ********
	// A 100 ns period.
	always #50 core_clk = ~core_clk;
	// One-cycle pulses are caught here so a check may look a little later.
	always @(posedge core_clk) begin
		if (classa_event_ff === 1'b1) seen_cla <= 1'b1;
		if (plateau_active_ff === 1'b1) seen_plat <= 1'b1;
	end
	task automatic cyc(input int k);
		repeat (k) @(negedge core_clk);
	endtask
	task automatic wr(input gdc_pkg::gdc_static_cfg_t v);
		static_wdata = v;
		static_wr = 1'b1;
		cyc(2);
		static_wr = 1'b0;
	endtask
	task automatic freeze();
		leave_config_command = 1'b1;
		cyc(1);
		leave_config_command = 1'b0;
	endtask
	task automatic setup(input gdc_pkg::gdc_opmode_t m);
		rst = 1'b1;
		opmode = gdc_pkg::GDC_OPM_CONFIG;
		cyc(5);
		rst = 1'b0;
		cyc(1);
		wr(c);
		freeze();
		opmode = m;
		cyc(2);
	endtask
	task automatic pulse(input logic [7:0] k);
		len = k;
		go = 1'b1;
		cyc(1);
		go = 1'b0;
	endtask
	task automatic count_plat();
		n = 0;
		repeat (20) begin
			cyc(1);
			if (plateau_active_ff === 1'b1) n++;
		end
	endtask
	task automatic shut();
		seen_cla = 1'b0;
		external_shutdown_pin = 1'b1;
		cyc(1);
		external_shutdown_pin = 1'b0;
		cyc(3);
	endtask
	task automatic final_report();
		$display("checks %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ********
	// Tests
	// ********
	// Each test starts from a reset, since static settings freeze until then.
	initial begin
		cyc(5);
		rst = 1'b0;
		cyc(1);
		`CHK(static_cfg_ff, '0)
		`CHK(active_clamp_output_ff, 1'b1)
		`CHK(verify_timeout_ff, 16'h03e8)
		c = '0;
		c.vbe_comp_enable = 1'b1;
		c.verify_timeout_select = 1'b1;
		wr(c);
		`CHK(static_cfg_ff, '0)
		opmode = gdc_pkg::GDC_OPM_CONFIG;
		wr(c);
		`CHK(vbe_comp_enable_ff, 1'b1)
		`CHK(verify_timeout_ff, VTO_L)
		freeze();
		wr('0);
		`CHK(static_cfg_ff, c)
		$display("test config done");
		c = '0;
		c.clamp_activation_time = 8'hff;
		c.shutdown_pin_classa_suppress = 1'b1;
		c.outstage_monitor_disable = 1'b1;
		c.desaturation_sense_clamp_enable = 1'b1;
		setup(gdc_pkg::GDC_OPM_NORMAL);
		`CHK(desaturation_sense_clamp_ff, 1'b1)
		`CHK(active_clamp_output_ff, 1'b0)
		pulse(8'h06);
		cyc(2);
		`CHK(outstage_monitoring_ff, 1'b0)
		cyc(6);
		`CHK(turn_off_output_ff, 1'b1)
		`CHK(seen_plat, 1'b0)
		shut();
		`CHK(seen_cla, 1'b0)
		`CHK(tristate_error_flag_ff, 1'b1)
		$display("test hard turn-off done");
		c = '0;
		c.regular_turnoff_delay_value = 8'h03;
		c.pulse_suppressor_enable = 1'b1;
		c.safe_turnoff_delay = 8'h06;
		c.safe_plateau_level = 4'h1;
		c.desaturation_sense_blanking_time = 8'h04;
		setup(gdc_pkg::GDC_OPM_NORMAL);
		`CHK(desaturation_sense_clamp_ff, 1'b0)
		`CHK(active_clamp_output_ff, 1'b1)
		plateau_wdata = 4'h9;
		weak_turnon_wdata = 4'h5;
		plateau_wr = 1'b1;
		weak_turnon_wr = 1'b1;
		cyc(1);
		plateau_wr = 1'b0;
		weak_turnon_wr = 1'b0;
		cyc(205);
		`CHK(secondary_plateau_in_use_ff, 4'h9)
		`CHK(primary_plateau_echo_ff, 4'h9)
		`CHK(regular_plateau_level_ctrl_ff, 4'h9)
		`CHK(weak_turnon_level_ctrl_ff, 4'h5)
		pulse(8'h0a);
		cyc(2);
		`CHK(turn_on_output_ff, 1'b1)
		`CHK(applied_turnon_level_ff, 4'h5)
		`CHK(desaturation_sense_blank_ff, 1'b1)
		`CHK(ocp_blank_ff, 1'b0)
		`CHK(outstage_monitoring_ff, 1'b1)
		cyc(8);
		pulse(8'h02);
		count_plat();
		`CHK(n inside {[4:8]}, 1'b1)
		`CHK(applied_plateau_ff, 4'h9)
		pulse(8'h1e);
		cyc(4);
		safe_turnoff_req = 1'b1;
		cyc(1);
		safe_turnoff_req = 1'b0;
		count_plat();
		`CHK(n inside {[10:14]}, 1'b1)
		`CHK(applied_plateau_ff, 4'h1)
		cyc(10);
		shut();
		`CHK(seen_cla, 1'b1)
		$display("test two-level turn-off done");
		c = '0;
		c.calibration_enable_field = 1'b1;
		setup(gdc_pkg::GDC_OPM_CALIB);
		pulse(8'h0a);
		cyc(5);
		`CHK(cal_busy_ff, 1'b1)
		cyc(8);
		`CHK(cal_busy_ff, 1'b0)
		`CHK(static_cfg_ff.regular_turnoff_delay_value inside {[8'h04:8'h06]}, 1'b1)
		$display("test calibration done");
		final_report();
	end
	// The tests need about 350 cycles; six times that means a hang.
	initial begin
		#(100 * 2100);
		bad_count++;
		final_report();
	end
endmodule
